// *** logic/discharge_guard.sv ***
// Cell discharge output control with forced-off schedule and thermal shutdown
`timescale 1ns/10ps
`include "discharge_guard_defines.svh"

// Operation
// - During a conversion with discharge-permit clear, outputs are held off in forced-off periods.
// - In periods that are not forced off, an enabled output is on between the forced drops at both ends of the period.
// - Outputs 5 to 12 are allowed on only in their scheduled periods, repeated for calibration.
// - With discharge-permit set, outputs are untouched for the whole conversion.
// - Outputs 1 to 4 follow the same schedule shifted as listed.
// - The thermal detector acts outside sleep and is ignored in sleep.
// - Over-temperature restores configuration defaults, turning all outputs off.
// - A thermal shutdown sets the thermal shutdown flag.
// - The flag holds until the status group B read, which clears it.
// - The clear-status command also acts on the flag (taken as clearing it).
module discharge_guard (
   input wire logic clock, // Core clock, 100 MHz
   input wire logic resetn, // Async reset, active low
   input wire logic sleepMode, // Device in sleep
   input wire logic overTempPin, // Die over-temperature comparator, async
   input wire logic configWrite, // Write pulse for discharge enables
   input wire logic [11:0] configData, // New cell_discharge_enable value
   input wire logic cellConvertCmd, // Start pulse of a cell conversion
   input wire logic dischargePermit, // Permit bit of that command
   input wire logic periodAdvance, // Pulse: conversion moves to next period
   input wire logic statusBRead, // Pulse: host reads status group B
   input wire logic clearStatusCmd, // Pulse: clear-status command
   output logic [11:0] dischargeOutput, // Discharge drives, output 1 in bit 0
   output logic [11:0] cellDischargeEnable, // Configuration enable bits
   output logic thermalShutdownFlag, // Sticky thermal shutdown flag
   output logic converting // Conversion in progress
);
   discharge_guard_pkg::conv_state_e state;
   logic [3:0] period;
   logic permit;
   logic tempSync1;
   logic tempSync2;
   logic thermalEvent;
   logic [11:0] allowMask;
   logic maskValid;
   logic configLoad;
   logic flagClear;
   logic startTaken;
   logic lastPeriod;
   logic periodEnd;
   logic masking;
   logic forceAll;

   // ----------------------------------------
   // Over-temperature synchroniser
   // ----------------------------------------
   // Parked while asleep: the detector is off then, and a stale hot
   // sample must not fire the moment the device wakes
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tempSync1 <= 1'b0;
      end else if (sleepMode) begin
         tempSync1 <= 1'b0;
      end else begin
         tempSync1 <= overTempPin;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tempSync2 <= 1'b0;
      end else if (sleepMode) begin
         tempSync2 <= 1'b0;
      end else begin
         tempSync2 <= tempSync1;
      end
   end

   assign thermalEvent = tempSync2 && !sleepMode;

   // ----------------------------------------
   // Configuration
   // ----------------------------------------
   // Thermal reset beats a simultaneous write so the die stays protected
   assign configLoad = configWrite && !thermalEvent;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cellDischargeEnable <= `DG_ENABLE_RESET;
      end else if (thermalEvent) begin
         cellDischargeEnable <= `DG_ENABLE_RESET;
      end else if (configLoad) begin
         cellDischargeEnable <= configData;
      end
   end

   // ----------------------------------------
   // Thermal shutdown flag
   // ----------------------------------------
   // Set wins over a clear in the same cycle
   assign flagClear = statusBRead || clearStatusCmd;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         thermalShutdownFlag <= 1'b0;
      end else if (thermalEvent) begin
         thermalShutdownFlag <= 1'b1;
      end else if (flagClear) begin
         thermalShutdownFlag <= 1'b0;
      end
   end

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   // A start is only taken in idle; a command during a conversion is dropped
   assign startTaken = (state == discharge_guard_pkg::IDLE) && cellConvertCmd;
   assign lastPeriod = (period == 4'(`DG_NUM_PERIODS - 1));
   assign periodEnd = (state == discharge_guard_pkg::CONVERT) && periodAdvance;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= discharge_guard_pkg::IDLE;
      end else begin
         case (state)
            discharge_guard_pkg::IDLE: begin
               if (cellConvertCmd) begin
                  state <= discharge_guard_pkg::CONVERT;
               end
            end
            discharge_guard_pkg::CONVERT: begin
               // Last advance of the calibration half ends the conversion
               if (periodAdvance && lastPeriod) begin
                  state <= discharge_guard_pkg::IDLE;
               end
            end
            default: begin
               state <= discharge_guard_pkg::IDLE;
            end
         endcase
      end
   end

   // Periods 0..5 measure, 6..11 calibrate with the same schedule
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         period <= 4'h0;
      end else if (startTaken) begin
         period <= 4'h0;
      end else if (periodEnd && lastPeriod) begin
         period <= 4'h0;
      end else if (periodEnd) begin
         period <= period + 4'h1;
      end
   end

   // Permit is latched with the command and holds for the whole conversion
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         permit <= 1'b1;
      end else if (startTaken) begin
         permit <= dischargePermit;
      end
   end

   // Registered so the status output never glitches on a state change
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         converting <= 1'b0;
      end else begin
         converting <= (state == discharge_guard_pkg::CONVERT);
      end
   end

   // Registered lookup: its output trails the period register by a cycle
   period_mask_rom maskRom (
      .clock(clock),
      .resetn(resetn),
      .period(period),
      .allowMask(allowMask)
   );

   // Both ends of a period drop every switch: the mask trails the period
   // by a cycle and would otherwise let a switch run into a forced-off slot
   assign masking = (state == discharge_guard_pkg::CONVERT) && !permit;
   assign forceAll = (startTaken && !dischargePermit) || (masking && periodAdvance);

   // Mask is valid one cycle after the period register settles
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         maskValid <= 1'b0;
      end else begin
         maskValid <= masking && !periodAdvance;
      end
   end

   // ----------------------------------------
   // Output drive
   // ----------------------------------------
   // One flop per switch, so each drive comes straight from a register
   generate
      for (genvar n = 0; n < `DG_NUM_OUTPUTS; n++) begin : g_drive
         logic allowed;
         assign allowed = maskValid && allowMask[n];

         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               dischargeOutput[n] <= 1'b0;
            end else if (forceAll) begin
               dischargeOutput[n] <= 1'b0;
            end else if (masking) begin
               dischargeOutput[n] <= cellDischargeEnable[n] && allowed;
            end else begin
               dischargeOutput[n] <= cellDischargeEnable[n];
            end
         end
      end
   endgenerate
endmodule

// *** logic/discharge_guard_defines.svh ***
// Constants for the cell discharge control and thermal guard
`ifndef DISCHARGE_GUARD_DEFINES_SVH
`define DISCHARGE_GUARD_DEFINES_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define DG_NUM_OUTPUTS 12
`define DG_NUM_PERIODS 12
`define DG_PERIOD_W 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DG_ENABLE_RESET 12'h000

// ----------------------------------------
// Allowed-on masks per period, bit n = output n+1
// Periods 0..5 measurement, 6..11 calibration (same pattern)
// ----------------------------------------
`define DG_ALLOW_P0 12'h71C
`define DG_ALLOW_P1 12'hE38
`define DG_ALLOW_P2 12'hC71
`define DG_ALLOW_P3 12'h8E3
`define DG_ALLOW_P4 12'h1C7
`define DG_ALLOW_P5 12'h38E

`endif

// *** logic/discharge_guard_pkg.sv ***
// Types for the cell discharge control and thermal guard
package discharge_guard_pkg;
   typedef enum logic [1:0] {IDLE, CONVERT} conv_state_e;
endpackage

// *** logic/period_mask_rom.sv ***
// Per-period allowed-on mask lookup with registered output
`timescale 1ns/10ps
`include "discharge_guard_defines.svh"
module period_mask_rom (
   input wire logic clock, // Core clock
   input wire logic resetn, // Async reset, active low
   input wire logic [3:0] period, // Conversion period 0..11
   output logic [11:0] allowMask // Outputs allowed on in that period
);
   logic [11:0] pattern;

   // Calibration periods repeat the measurement pattern
   always_comb begin
      case ((period >= 4'h6) ? period - 4'h6 : period)
         4'h0: pattern = `DG_ALLOW_P0;
         4'h1: pattern = `DG_ALLOW_P1;
         4'h2: pattern = `DG_ALLOW_P2;
         4'h3: pattern = `DG_ALLOW_P3;
         4'h4: pattern = `DG_ALLOW_P4;
         4'h5: pattern = `DG_ALLOW_P5;
         default: pattern = 12'h000;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         allowMask <= 12'h000;
      end else begin
         allowMask <= pattern;
      end
   end
endmodule

// *** tb/discharge_guard_asserts.sv ***
// Port-level assertions for the discharge guard
`timescale 1ns/10ps
module discharge_guard_asserts (
   input wire logic clock, // Core clock
   input wire logic resetn, // Async reset, active low
   input wire logic sleepMode, // Device in sleep
   input wire logic overTempPin, // Over-temperature level
   input wire logic cellConvertCmd, // Conversion start pulse
   input wire logic dischargePermit, // Permit bit
   input wire logic statusBRead, // Status group B read pulse
   input wire logic clearStatusCmd, // Clear-status pulse
   input wire logic [11:0] dischargeOutput, // Discharge drives
   input wire logic [11:0] cellDischargeEnable, // Enable bits
   input wire logic thermalShutdownFlag, // Sticky flag
   input wire logic converting // Conversion running
);
   logic permitSeen;
   logic [3:0] hotHist;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // Pin history, since a heat event may still be in the synchroniser
   always_ff @(posedge clock or negedge resetn)
      if (!resetn) hotHist <= 4'h0;
      else hotHist <= {hotHist[2:0], overTempPin};
   always_ff @(posedge clock or negedge resetn)
      if (!resetn) permitSeen <= 1'h0;
      else if (cellConvertCmd && !converting) permitSeen <= dischargePermit;
   property p_sub; (dischargeOutput & ~$past(cellDischargeEnable)) == 12'h000; endproperty
   a_sub: assert property (p_sub) else $error("drive on without enable");
   property p_start;
      cellConvertCmd && !converting && !dischargePermit |=> dischargeOutput == 12'h000;
   endproperty
   a_start: assert property (p_start) else $error("drive on at conversion start");
   property p_permit;
      converting && permitSeen |-> dischargeOutput == $past(cellDischargeEnable);
   endproperty
   a_permit: assert property (p_permit) else $error("drive altered with permit");
   property p_setf;
      $rose(thermalShutdownFlag) |-> $past(overTempPin, 3) && cellDischargeEnable == 12'h000;
   endproperty
   a_setf: assert property (p_setf) else $error("flag set without heat");
   property p_off; $rose(thermalShutdownFlag) |=> dischargeOutput == 12'h000; endproperty
   a_off: assert property (p_off) else $error("drive on after heat");
   property p_bclr; statusBRead && hotHist == 4'h0 && !overTempPin |=> !thermalShutdownFlag; endproperty
   a_bclr: assert property (p_bclr) else $error("flag kept after read");
   property p_cclr; clearStatusCmd && hotHist == 4'h0 && !overTempPin |=> !thermalShutdownFlag; endproperty
   a_cclr: assert property (p_cclr) else $error("flag kept after clear");
   property p_sleep; sleepMode && !thermalShutdownFlag |=> !thermalShutdownFlag; endproperty
   a_sleep: assert property (p_sleep) else $error("flag set in sleep");
   property p_busy; $rose(converting) |-> $past(cellConvertCmd, 2); endproperty
   a_busy: assert property (p_busy) else $error("conversion flag without command");
   c_conv: cover property (cellConvertCmd && !converting);
   c_heat: cover property ($rose(thermalShutdownFlag));
   c_perm: cover property (converting && permitSeen);
endmodule
bind discharge_guard discharge_guard_asserts u_chk (.*);

// *** tb/host_model.sv ***
// Host controller model issuing commands to the discharge guard
`timescale 1ns/10ps
module host_model (
   input wire logic clock, // Core clock
   output logic sleepMode, // Sleep level
   output logic overTempPin, // Die heat level
   output logic configWrite, // Config write pulse
   output logic [11:0] configData, // Enable bits
   output logic cellConvertCmd, // Conversion pulse
   output logic dischargePermit, // Permit bit
   output logic periodAdvance, // Period pulse
   output logic statusBRead, // Status read pulse
   output logic clearStatusCmd // Clear-status pulse
);
   initial {sleepMode, overTempPin, configWrite, configData, cellConvertCmd} = '0;
   initial {dischargePermit, periodAdvance, statusBRead, clearStatusCmd} = '0;
   // One-cycle strobe k, data held with it
   task automatic pulse(input int k, input logic [11:0] d, input logic p);
      @(posedge clock) #1 configData = d;
      dischargePermit = p;
      {configWrite, cellConvertCmd, periodAdvance, statusBRead, clearStatusCmd} = 5'h10 >> k;
      @(posedge clock) #1 {configWrite, cellConvertCmd, periodAdvance, statusBRead} = 4'h0;
      clearStatusCmd = 1'h0;
   endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the discharge guard
`timescale 1ns/10ps
module tb;
   logic clock, resetn, sleepMode, overTempPin, configWrite, cellConvertCmd, dischargePermit;
   logic periodAdvance, statusBRead, clearStatusCmd, thermalShutdownFlag, converting, perm;
   logic [11:0] configData, dischargeOutput, cellDischargeEnable, en;
   logic [12:0] expq[$];
   int miscompares = 0;
   int check_count = 0;
   event look;
   host_model u_host (.*);
   discharge_guard u_dut (.*);
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   function automatic logic [11:0] allow(input int p);
      for (int n = 0; n < 12; n++) allow[n] = ((p - n % 6 + 10) % 6) < 3;
   endfunction
   task automatic note(input logic [12:0] e);
      @(posedge clock) #1 expq.push_back(e);
      ->look;
   endtask
   always @(look) begin
      check_count++;
      if ({thermalShutdownFlag, dischargeOutput} !== expq[0]) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, {thermalShutdownFlag, dischargeOutput}, expq[0]);
      end
      void'(expq.pop_front());
   end
   task automatic heat;
      @(posedge clock) #1 u_host.overTempPin = 1'h1;
      for (int i = 0; i < 9 && thermalShutdownFlag !== 1'h1; i++) @(posedge clock) #1;
      if (thermalShutdownFlag !== 1'h1) begin
         miscompares++;
         report_and_stop();
      end
      u_host.overTempPin = 1'h0;
      repeat (4) @(posedge clock);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      resetn = 1'h0;
      void'($urandom(32'h6AB572D6));
      repeat (5) @(posedge clock);
      #1 resetn = 1'h1;
      for (int t = 0; t < 10; t++) begin
         en = (t < 4) ? 12'($urandom) : 12'h041 << (t - 4);
         perm = (t < 4) ? t[0] : 1'h1;
         u_host.pulse(0, en, 1'h0);
         note({1'h0, en});
         u_host.pulse(1, en, perm);
         for (int p = 0; p < 12; p++) begin
            repeat (3) @(posedge clock);
            note({1'h0, perm ? en : en & allow(p)});
            u_host.pulse(2, en, 1'h0);
         end
         $display("conversion test %0d done", t);
      end
      u_host.pulse(0, 12'hFFF, 1'h0);
      u_host.sleepMode = 1'h1;
      u_host.overTempPin = 1'h1;
      repeat (6) @(posedge clock);
      note(13'h0FFF);
      u_host.sleepMode = 1'h0;
      heat();
      note(13'h1000);
      u_host.pulse(3, 12'h000, 1'h0);
      note(13'h0000);
      heat();
      u_host.pulse(4, 12'h000, 1'h0);
      note(13'h0000);
      $display("thermal test done");
      @(posedge clock);
      report_and_stop();
   end
endmodule
